// File: hw/rx_align_consts.svh
/*
  Timing counts, widths and reset values for the receive lane alignment block.
  Assumes inclusion by bare name from design files under hw/.
*/
`ifndef RX_ALIGN_CONSTS_SVH
`define RX_ALIGN_CONSTS_SVH

// Fixed reference-to-boundary delay in byte clocks
`define REF_TO_BOUNDARY_BYTE_CLOCKS 16
// Octets moved per core clock cycle
`define OCTETS_PER_CYCLE 4
// Pipeline cycles inside the fixed reference-to-boundary delay
`define REF_TO_BOUNDARY_CYCLES (`REF_TO_BOUNDARY_BYTE_CLOCKS / `OCTETS_PER_CYCLE)
// Reference delay setting range and width
`define REF_DELAY_MAX 15
`define REF_DELAY_W 4
`define REF_DELAY_RESET 4'h0
// Fill-level readout width in bits; the readout counts octets
`define FILL_W 10
// Target window half width in core cycles (software guidance)
`define TARGET_WINDOW_CYCLES 2
// Default multiframe length in core cycles
`define MF_CYCLES_DEFAULT 8
// Default lane count and lane word width
`define LANES_DEFAULT 4
`define LANE_DATA_W_DEFAULT 32

`endif

// File: hw/rx_align_pkg.sv
/*
  Types shared by the receive lane alignment block.
  Assumes no other package.
*/
package rx_align_pkg;
  typedef enum logic [1:0] {
    ALIGN_IDLE,
    ALIGN_WAIT_REF,
    ALIGN_WAIT_LANES,
    ALIGN_RUN
  } align_state_t;
endpackage

// File: hw/lane_fifo.sv
/*
  Per-lane alignment buffer: flip-flop storage indexed by pointers, with a
  live fill count. Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`include "rx_align_consts.svh"

module lane_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  output logic [WIDTH-1:0] rd_data,
  output logic not_empty,
  output logic overflow,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [$clog2(DEPTH+1)-1:0] level_reg;
  logic do_wr;
  logic do_rd;

  // Reads only when data is held; writes drop when full with no read in the same cycle
  assign do_rd = rd_en && (level_reg != '0);
  assign do_wr = wr_en && ((level_reg != DEPTH[$clog2(DEPTH+1)-1:0]) || do_rd);

  // Storage write
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_reg[wptr_reg] <= wr_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (reset) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      level_reg <= '0;
    end else begin
      if (do_wr) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
      end
      if (do_rd) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
      end
      level_reg <= level_reg + (do_wr ? 1'b1 : 1'b0) - (do_rd ? 1'b1 : 1'b0);
    end
  end

  // Sticky overflow, cleared only by reset
  always_ff @(posedge clk) begin
    if (reset) begin
      overflow <= 1'b0;
    end else if (wr_en && !do_wr) begin
      overflow <= 1'b1;
    end
  end

  assign rd_data = mem_reg[rptr_reg];
  assign not_empty = (level_reg != '0);
  assign level = level_reg;
endmodule

// File: hw/skid_buffer.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps

module skid_buffer #(
  parameter int WIDTH = 128
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] slot_reg [2];
  logic rd_reg;
  logic wr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = slot_reg[rd_reg];

  // Entry storage
  always_ff @(posedge clk) begin
    if (push) begin
      slot_reg[wr_reg] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_reg <= ~wr_reg;
      end
      if (pop) begin
        rd_reg <= ~rd_reg;
      end
      count_reg <= count_reg + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
    end
  end
endmodule

// File: hw/rx_lane_align_latency_control.sv
/*
  Receive deterministic latency logic: per-lane alignment buffers released on
  a local multiframe boundary, fill-level capture, programmable reference
  delay and a two-entry output buffer. Assumes lane data already on the core
  clock; the reference strobe arrives from a pin and is synchronised here.
*/
// Function
// RULE1: Lane buffers absorb variable input delay so end-to-end latency repeats.
// RULE2: Reference to boundary fixed at 16 byte clocks; no delay boundary to output; the code presents output one cycle after the boundary.
// RULE3: Reference-to-boundary and boundary-to-output fixed; input-to-boundary may vary.
// RULE4: Latency fixed by default, adjustable by the reference delay setting.
// RULE5: Each lane reports buffer fill captured at the releasing boundary.
// RULE6: Fill level counted in octets, four octets per core cycle.
// RULE7: Release only when every lane holds valid data.
// RULE8: Delay setting shifts boundaries later by whole cycles, one step four octets.
// RULE9: Software should tune delay so data starts within two cycles of boundary.
// RULE10: Reference delay takes 0 to 15 cycles, before boundary counter reset.
// RULE11: Changed delay acts only after core reset and realignment.
// RULE12: Data released on first boundary after all lanes hold valid data.
// RULE13: Fill readout per lane is a 10-bit octet count of pointer difference.
// RULE14: Fill readout holds until next alignment releases data; the code clears it to zero at reset, so it reads zero until release.
// RULE15: Lane buffers hold at least one full multiframe of octets.
`timescale 1ns/100ps
`include "rx_align_consts.svh"

module rx_lane_align_latency_control
  import rx_align_pkg::*;
#(
  parameter int LANES = `LANES_DEFAULT,
  parameter int LANE_DATA_W = `LANE_DATA_W_DEFAULT,
  parameter int MF_CYCLES = `MF_CYCLES_DEFAULT,
  parameter int BUF_DEPTH = 2 * `MF_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic reference_pin,
  input wire logic [`REF_DELAY_W-1:0] reference_delay,
  input wire logic [LANES-1:0] lane_valid,
  input wire logic [LANES*LANE_DATA_W-1:0] lane_data,
  output logic [LANES*`FILL_W-1:0] lane_fill,
  output logic [LANES-1:0] lane_overflow,
  output logic aligned,
  output logic boundary_pulse,
  output logic out_valid,
  input wire logic out_ready,
  output logic [LANES*LANE_DATA_W-1:0] out_data
);
  // Fixed pipeline cycles inside the reference-to-boundary delay
  localparam int FIXED_CYC = `REF_TO_BOUNDARY_CYCLES;

  // Multiframe counter width, at least one bit
  localparam int MFW = (MF_CYCLES > 1) ? $clog2(MF_CYCLES) : 1;

  // Lane buffer level width, room for a full buffer
  localparam int LVW = $clog2(BUF_DEPTH + 1);

  // Delay counter width: programmed delay plus fixed pipeline
  localparam int DLYW = `REF_DELAY_W + 3;

  // Alignment sequence state
  align_state_t state_reg;

  // Reference strobe synchroniser and edge detect
  logic ref_meta_reg;
  logic ref_sync_reg;
  logic ref_prev_reg;
  logic ref_event;

  // Delay between reference event and counter reset
  logic [`REF_DELAY_W-1:0] delay_latched_reg;
  logic [DLYW-1:0] delay_cnt_reg;
  logic delay_busy_reg;
  logic boundary_reset;

  // Local multiframe counter
  logic [MFW-1:0] mf_cnt_reg;
  logic mf_running_reg;
  logic boundary;

  // Per-lane buffer status and read data
  logic [LANES-1:0] lane_has_data;
  logic [LANES-1:0] lane_ovf;
  logic [LVW-1:0] lane_level [LANES];
  logic [LANE_DATA_W-1:0] lane_rd [LANES];

  // Release and lockstep read towards the output buffer
  logic release_now;
  logic fifo_rd;
  logic sk_in_ready;
  logic [LANES*LANE_DATA_W-1:0] sk_in_data;

  // Reference strobe passes two flip-flops before any logic looks at it
  always_ff @(posedge clk) begin
    if (reset) begin
      ref_meta_reg <= 1'b0;
      ref_sync_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
    end else begin
      ref_meta_reg <= reference_pin;
      ref_sync_reg <= ref_meta_reg;
      ref_prev_reg <= ref_sync_reg;
    end
  end


  // Rising edge of the synchronised strobe; prev resets to the idle low level
  assign ref_event = ref_sync_reg && !ref_prev_reg;


  // Delay setting captured once after reset release; later changes wait for reset
  always_ff @(posedge clk) begin
    if (reset) begin
      delay_latched_reg <= `REF_DELAY_RESET;
    end else if (state_reg == ALIGN_IDLE) begin
      delay_latched_reg <= reference_delay; // see RULE11 see RULE4
    end
  end

  // Fixed pipeline plus programmed cycles between event and counter reset
  always_ff @(posedge clk) begin
    if (reset) begin
      delay_cnt_reg <= '0;
      delay_busy_reg <= 1'b0;
    end else if (state_reg == ALIGN_WAIT_REF && ref_event && !delay_busy_reg) begin
      delay_busy_reg <= 1'b1;
      // see RULE2 see RULE8 see RULE10
      delay_cnt_reg <= DLYW'(FIXED_CYC - 1) + DLYW'(delay_latched_reg);
    end else if (delay_busy_reg) begin
      if (delay_cnt_reg == '0) begin
        delay_busy_reg <= 1'b0;
      end else begin
        delay_cnt_reg <= delay_cnt_reg - 1'b1;
      end
    end
  end


  // Last cycle of the delay: this cycle is the first boundary
  assign boundary_reset = delay_busy_reg && (delay_cnt_reg == '0);


  // Local multiframe counter, free running from the first boundary
  always_ff @(posedge clk) begin
    if (reset) begin
      mf_cnt_reg <= '0;
      mf_running_reg <= 1'b0;
    end else if (boundary_reset) begin
      // Boundary cycle itself is count zero, so the next cycle is count one
      mf_cnt_reg <= MFW'(1 % MF_CYCLES); // see RULE10
      mf_running_reg <= 1'b1;
    end else if (mf_running_reg) begin
      mf_cnt_reg <= (mf_cnt_reg == MFW'(MF_CYCLES - 1)) ? '0 : mf_cnt_reg + 1'b1;
    end
  end

  // Boundary: counter at zero, constant phase to the reference; see RULE3

  assign boundary = boundary_reset || (mf_running_reg && mf_cnt_reg == '0);


  // Alignment sequence
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ALIGN_IDLE;
    end else begin
      case (state_reg)
        ALIGN_IDLE: begin
          state_reg <= ALIGN_WAIT_REF;
        end

        // First boundary may already release if every lane holds data
        ALIGN_WAIT_REF: begin
          if (release_now) begin
            state_reg <= ALIGN_RUN;
          end else if (boundary_reset) begin
            state_reg <= ALIGN_WAIT_LANES;
          end
        end

        ALIGN_WAIT_LANES: begin
          if (release_now) begin
            state_reg <= ALIGN_RUN;
          end
        end

        // Released; only reset leaves this state
        ALIGN_RUN: begin
          state_reg <= ALIGN_RUN;
        end

        default: begin
          state_reg <= ALIGN_IDLE;
        end
      endcase
    end
  end

  // First boundary with every lane holding data releases output

  // First boundary with every lane holding data releases output
  // Includes the boundary that ends the reference delay
  assign release_now = ((state_reg == ALIGN_WAIT_LANES)
    || (state_reg == ALIGN_WAIT_REF && boundary_reset))
    && boundary
    && (&lane_has_data); // see RULE7 see RULE12


  // Lane buffers sized to a multiframe or more
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : lane_g
      lane_fifo #(
        .WIDTH(LANE_DATA_W),
        .DEPTH(BUF_DEPTH) // see RULE15
      ) fifo_i (
        .clk(clk),
        .reset(reset),
        .wr_en(lane_valid[g] && state_reg != ALIGN_IDLE), // see RULE1
        .wr_data(lane_data[g*LANE_DATA_W +: LANE_DATA_W]),
        .rd_en(fifo_rd),
        .rd_data(lane_rd[g]),
        .not_empty(lane_has_data[g]),
        .overflow(lane_ovf[g]),
        .level(lane_level[g])
      );

      // Fill captured at release in octets and held; see RULE5 see RULE14
      always_ff @(posedge clk) begin
        if (reset) begin
          lane_fill[g*`FILL_W +: `FILL_W] <= '0;
        end else if (release_now) begin
          // see RULE6 see RULE13
          lane_fill[g*`FILL_W +: `FILL_W] <=
            `FILL_W'(lane_level[g]) * `FILL_W'(`OCTETS_PER_CYCLE);
        end
      end

      assign sk_in_data[g*LANE_DATA_W +: LANE_DATA_W] = lane_rd[g];
    end
  endgenerate


  // All lanes read in lockstep; a receiver stall holds every lane
  assign fifo_rd = (release_now || state_reg == ALIGN_RUN) && (&lane_has_data)
    && sk_in_ready;


  // Output buffer straight after release; its register puts words on the output one cycle after the boundary
  // Two entries keep the word in flight when the client drops ready
  skid_buffer #(
    .WIDTH(LANES * LANE_DATA_W)
  ) out_buf_i (
    .clk(clk),
    .reset(reset),
    .in_valid(fifo_rd),
    .in_ready(sk_in_ready),
    .in_data(sk_in_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );


  // Aligned flag, high from the cycle after release
  always_ff @(posedge clk) begin
    if (reset) begin
      aligned <= 1'b0;
    end else begin
      aligned <= (state_reg == ALIGN_RUN) || release_now;
    end
  end

  // Boundary marker, one cycle after each internal boundary
  always_ff @(posedge clk) begin
    if (reset) begin
      boundary_pulse <= 1'b0;
    end else begin
      boundary_pulse <= boundary;
    end
  end

  // Sticky lane overflow copied out of the buffers
  always_ff @(posedge clk) begin
    if (reset) begin
      lane_overflow <= '0;
    end else begin
      lane_overflow <= lane_ovf;
    end
  end
endmodule

// File: verif/adc_lane_model.sv
/*
  Far-side lane source: one word a cycle per lane, each lane starting late by its skew.
  Assumes the core clock and the synchronous reset of the bench.
*/
`timescale 1ns/100ps
module adc_lane_model #(
  parameter int LANES = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [LANES*3-1:0] skew,
  output logic [LANES-1:0] lane_valid,
  output logic [LANES*32-1:0] lane_data
);
  logic [23:0] t_reg;
  logic [23:0] f_reg;
  // Word index since start, and a free count for idle data
  always_ff @(posedge clk) begin
    t_reg <= (reset || !go) ? 24'h0 : t_reg + 24'h1;
    f_reg <= reset ? 24'h0 : f_reg + 24'h1;
  end
  // Skewed lane start; idle lines keep changing
  always_comb begin
    for (int g = 0; g < LANES; g++) begin
      lane_valid[g] = go && (t_reg >= 24'(skew[g*3+:3]));
      lane_data[g*32+:32] = {8'(g), lane_valid[g] ? t_reg : f_reg};
    end
  end
endmodule

// File: verif/rx_align_props.sv
/*
  Port checker for the lane alignment block.
  Assumes binding into the top module with its own parameters.
*/
`timescale 1ns/100ps
`include "rx_align_consts.svh"
module rx_align_props #(
  parameter int LANES = 4,
  parameter int LANE_DATA_W = 32,
  parameter int BUF_DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [LANES*`FILL_W-1:0] lane_fill,
  input wire logic [LANES-1:0] lane_overflow,
  input wire logic aligned,
  input wire logic boundary_pulse,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [LANES*LANE_DATA_W-1:0] out_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Per-lane fill and overflow checks
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    a_fill_octets: assert property (lane_fill[g*`FILL_W+:2] == 2'h0)
      else $error("fill not in whole words");
    a_fill_bound: assert property (lane_fill[g*`FILL_W+:`FILL_W] <= 10'(BUF_DEPTH*4))
      else $error("fill above buffer size");
    a_fill_nonzero: assert property ($rose(aligned) |-> lane_fill[g*`FILL_W+:`FILL_W] != 0)
      else $error("release with an empty lane");
    a_overflow_sticky: assert property (lane_overflow[g] |=> lane_overflow[g])
      else $error("overflow flag cleared");
  end
  a_release_together: assert property ($rose(aligned) |-> out_valid && boundary_pulse)
    else $error("release off boundary");
  a_valid_needs_align: assert property (out_valid |-> aligned)
    else $error("output before release");
  a_boundary_period: assert property (boundary_pulse && aligned |=> !boundary_pulse [*7] ##1 boundary_pulse)
    else $error("boundary spacing wrong");
  a_fill_holds: assert property (aligned && $past(aligned) |-> $stable(lane_fill))
    else $error("fill changed after release");
  a_fill_pre_zero: assert property (!aligned |-> lane_fill == '0)
    else $error("fill set before release");
  a_stall_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("word lost in stall");
  c_release: cover property ($rose(aligned));
  c_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
  c_overflow: cover property ($rose(lane_overflow[0]));
endmodule
bind rx_lane_align_latency_control rx_align_props #(.LANES(LANES), .LANE_DATA_W(LANE_DATA_W),
  .BUF_DEPTH(BUF_DEPTH)) u_rx_align_props (.clk(clk), .reset(reset), .lane_fill(lane_fill),
  .lane_overflow(lane_overflow), .aligned(aligned), .boundary_pulse(boundary_pulse),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));

// File: verif/test_rx_lane_align_latency_control.sv
/*
  Self-checking bench: random skew and delay, client stalls, overflow.
  Assumes the package, the constants header and the lane model.
*/
`timescale 1ns/100ps
`include "rx_align_consts.svh"
module test_rx_lane_align_latency_control;
  import rx_align_pkg::*;
  logic clk = 0, reset = 1, reference_pin = 0, out_ready = 0, go = 0;
  logic [3:0] reference_delay = 4'h0;
  logic [11:0] skew = 12'h0;
  logic [3:0] lane_valid, lane_overflow;
  logic [127:0] lane_data, out_data;
  logic [39:0] lane_fill;
  logic aligned, boundary_pulse, out_valid;
  int err_total = 0, tests_run = 0, cyc = 0;
  logic [15:0] lfsr = 16'h3E18;
  rx_lane_align_latency_control u_rx_lane_align_latency_control (.clk(clk), .reset(reset),
    .reference_pin(reference_pin), .reference_delay(reference_delay), .lane_valid(lane_valid),
    .lane_data(lane_data), .lane_fill(lane_fill), .lane_overflow(lane_overflow),
    .aligned(aligned), .boundary_pulse(boundary_pulse), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  adc_lane_model u_adc_lane_model (.clk(clk), .reset(reset), .go(go), .skew(skew),
    .lane_valid(lane_valid), .lane_data(lane_data));
  // Clock and cycle count
  initial forever #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // First boundary at which every lane holds a word
  function automatic int exp_release(input int b, input int need);
    while (b < need) b += 8;
    return b;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("err_total %0d tests_run %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One link start: reset, reference, skewed lanes, stalled drain
  task automatic run(input int i, input logic [3:0] d, input bit keep);
    int p, gc, ms, r, k, n;
    @(negedge clk);
    reference_delay = d;
    reset = 1;
    go = 0;
    out_ready = 0;
    ms = 0;
    for (int g = 0; g < 4; g++) begin
      lfsr = lfsr_next(lfsr);
      skew[g*3+:3] = (i == 0) ? 3'h0 : lfsr[2:0];
      if (int'(skew[g*3+:3]) > ms) ms = skew[g*3+:3];
    end
    repeat (10) @(negedge clk);
    reset = 0;
    repeat (3) @(negedge clk);
    p = cyc;
    reference_pin = 1;
    gc = p + d + 3;
    k = 0;
    r = exp_release(p + 6 + d, gc + ms + 1);
    while (cyc < r + 40) begin
      n = cyc;
      if (n == p + 3 || n == r + 5) reference_pin = 0;
      if (n == r + 3) begin
        reference_pin = 1;
        reference_delay = lfsr[3:0];
      end
      if (n == gc) go = 1;
      if (n == r + 1 && !keep) go = 0;
      if (n >= p + 7 + d) check("boundary", (n - p - 7 - d) % 8 == 0, boundary_pulse);
      check("aligned", n > r, aligned);
      if (n <= r + 1) check("out_valid", n == r + 1, out_valid);
      if (n == r + 1)
        for (int g = 0; g < 4; g++)
          check("fill", 32'((r - gc - skew[g*3+:3]) * 4), lane_fill[g*10+:10]);
      // Ready for the coming edge, then look at the word that edge will take
      lfsr = lfsr_next(lfsr);
      out_ready = (n < r + 2 || (n > r + 7 && !keep)) && (lfsr[0] || lfsr[1]);
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
        for (int g = 0; g < 4; g++)
          check("data", {8'(g), 24'(skew[g*3+:3] + k)}, out_data[g*32+:32]);
        k++;
      end
      @(negedge clk);
    end
    for (int g = 0; g < 4; g++)
      check("fill held", 32'((r - gc - skew[g*3+:3]) * 4), lane_fill[g*10+:10]);
    if (!keep) check("words", r + 1 - gc - ms, k);
    check("overflow", keep ? 4'hF : 4'h0, lane_overflow);
  endtask
  // Delay corners, random delays, last start overflows
  initial begin
    for (int i = 0; i < 5; i++) begin
      lfsr = lfsr_next(lfsr);
      run(i, i == 0 ? 4'h0 : i == 1 ? 4'hF : lfsr[7:4], i == 4);
    end
    final_report();
  end
  // Watchdog on a hung run
  initial begin
    #100000;
    err_total++;
    final_report();
  end
endmodule
